// ==== rtl/dpc_pkg.sv ====
// dpc_pkg.sv: timing figures, pin and request carriers for the
// page cycle controller of a 1M x 16 asynchronous DRAM.
// assumes: a single 100 MHz system clock drives every user of it.
package dpc_pkg;

  // ***************************************************************
  // clock, widths and grades
  // ***************************************************************
  localparam int CLK_PERIOD_PS = 10000;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int CNT_W = 8;
  localparam int WAKE_W = 4;
  localparam int GRADES = 3;
  localparam int GRADE_FAST = 0;

  // ***************************************************************
  // cycle figures in ns, one entry per grade, fastest first; T_RAD_NS, T_RAH_NS and T_ODD_NS serve all grades, LATE_GAP_CYC is in cycles
  // ***************************************************************
  localparam int T_RC_NS [GRADES] = '{110, 130, 150};
  localparam int T_RWC_NS [GRADES] = '{155, 180, 200};
  localparam int T_RP_NS [GRADES] = '{40, 50, 60};
  localparam int T_RAS_NS [GRADES] = '{60, 70, 80};
  localparam int T_RMW_RAS_NS [GRADES] = '{105, 120, 130};
  localparam int T_CAS_NS [GRADES] = '{15, 20, 20};
  localparam int T_RMW_CAS_NS [GRADES] = '{60, 70, 70};
  localparam int T_CSH_NS [GRADES] = '{60, 70, 80};
  localparam int T_RSH_NS [GRADES] = '{15, 20, 20};
  localparam int T_RMW_RSH_NS [GRADES] = '{60, 70, 70};
  localparam int T_RAL_NS [GRADES] = '{30, 35, 40};
  localparam int T_OCH_NS [GRADES] = '{15, 20, 20};
  localparam int T_ORH_NS [GRADES] = '{15, 20, 20};
  localparam int T_CAC_NS [GRADES] = '{15, 20, 20};
  localparam int T_RAC_NS [GRADES] = '{60, 70, 80};
  localparam int T_AA_NS [GRADES] = '{30, 35, 40};
  localparam int T_OEA_NS [GRADES] = '{15, 20, 20};
  localparam int T_WCH_NS [GRADES] = '{10, 10, 15};
  localparam int T_CWL_NS [GRADES] = '{15, 20, 20};
  localparam int T_RWL_NS [GRADES] = '{15, 20, 20};
  localparam int T_WP_NS [GRADES] = '{10, 10, 15};
  localparam int T_DH_NS [GRADES] = '{10, 15, 15};
  localparam int T_CWD_NS [GRADES] = '{40, 45, 45};
  localparam int T_RWD_NS [GRADES] = '{85, 95, 105};
  localparam int T_AWD_NS [GRADES] = '{55, 60, 65};
  localparam int T_RAD_NS = 15;
  localparam int T_RAH_NS = 10;
  localparam int T_ODD_NS = 15;
  localparam int LATE_GAP_CYC = 1;

  // ***************************************************************
  // start-up and idle supervision
  // ***************************************************************
  localparam int T_POWERUP_US = 500;
  localparam real T_IDLE_MS = 16.4;
  localparam int POWERUP_CYC = T_POWERUP_US * 1000000 / CLK_PERIOD_PS;
  // longest time: truncation rounds down
  localparam int IDLE_CYC = $rtoi(T_IDLE_MS * 1.0e9 / CLK_PERIOD_PS);
  localparam int WAKE_CYCLES = 8;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef enum logic [1:0] {
    DPC_READ, DPC_EARLY_WRITE, DPC_LATE_WRITE, DPC_RMW
  } dpc_kind_type;

  typedef struct packed {
    dpc_kind_type kind;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic [DATA_W-1:0] wdata;
  } dpc_req_type;

  typedef struct packed {
    logic rowStrobeN;
    logic colStrobeN;
    logic storeStrobeN;
    logic outGateN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dqOut;
    logic dqOe;
  } dpc_pins_type;

  // least time in ns to whole cycles, never under one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

endpackage

// ==== rtl/dpc_timer.sv ====
// dpc_timer.sv: down counter that times each phase of a DRAM cycle.
// assumes: load and value settle before the clock edge they meet.
`timescale 1ns/1ps
`default_nettype none
module dpc_timer #(
  parameter int W = 16
) (
  input wire logic clk, // system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic load, // restart the count
  input wire logic [W-1:0] value, // cycles left after this one
  output logic done // count stands at zero
);
  typedef struct packed {
    logic [W-1:0] count;
  } dpc_timer_type;

  dpc_timer_type st;
  dpc_timer_type next_st;

  // load wins over the count so a phase may restart back to back
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.count = value;
    end else if (st.count != '0) begin
      next_st.count = st.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = (st.count == '0);
endmodule
`default_nettype wire

// ==== rtl/dpc_row_watch.sv ====
// dpc_row_watch.sv: counts cycles since the row strobe last fell
// and flags when the memory has gone too long without one.
// assumes: fell is a one-cycle pulse from the cycle sequencer.
`timescale 1ns/1ps
`default_nettype none
module dpc_row_watch #(
  parameter int LIMIT = 1000,
  parameter int W = 21
) (
  input wire logic clk, // system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic fell, // row strobe has just gone low
  output logic stale // quiet longer than the limit
);
  typedef struct packed {
    logic [W-1:0] count;
  } dpc_watch_type;

  dpc_watch_type st;
  dpc_watch_type next_st;

  // saturates so a very long quiet spell never wraps back to fresh
  always_comb begin
    next_st = st;
    if (fell) begin
      next_st.count = '0;
    end else if (st.count != '1) begin
      next_st.count = st.count + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stale = (int'(st.count) >= LIMIT);
endmodule
`default_nettype wire

// ==== rtl/dpc_page_cycle.sv ====
// dpc_page_cycle.sv: controller that runs single random read, early
// write, delayed write and read-modify-write cycles on a 1M x 16 DRAM.
// assumes: pins are registered onto the board, dqIn is synchronous.
// Notes on behaviour
// - row strobe low at least minimum width
// - column strobe low at least minimum width
// - column strobe stays low after row falls
// - row strobe stays low after column falls
// - store strobe high throughout every read
// - column address held before row rises
// - column strobe held after output gate falls
// - row strobe held after output gate falls
// - early write: store strobe low first
// - column strobe held after store falls
// - row strobe held after store falls
// - write data valid at latching edge
// - write data held after latching edge
// - delayed write: output gate high beforehand
// - read-modify-write cycle time minimum met
// - read-modify-write row low minimum width
// - store falls late after column falls
// - store falls late after row falls
// - store falls late after column address
// - strobe delays only classify the cycle
// - power-up pause then eight row cycles
`timescale 1ns/1ps
`default_nettype none
module dpc_page_cycle #(
  parameter int GRADE = dpc_pkg::GRADE_FAST,
  parameter int POWERUP_CYC = dpc_pkg::POWERUP_CYC,
  parameter int IDLE_CYC = dpc_pkg::IDLE_CYC
) (
  input wire logic clk, // system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic reqValid, // request offered
  output logic reqReady, // request taken when both high
  input wire dpc_pkg::dpc_req_type req, // kind, address, data
  output logic rspValid, // one-cycle end-of-cycle pulse
  output logic [dpc_pkg::DATA_W-1:0] rspData, // word read
  output dpc_pkg::dpc_pins_type pins, // strobes, address, data out
  input wire logic [dpc_pkg::DATA_W-1:0] dqIn // data pins as read
);

  // ***************************************************************
  // cycle counts for the chosen grade
  // ***************************************************************
  // all figures rounded up to whole clocks at design time
  localparam int C_RC = dpc_pkg::cyc_up(dpc_pkg::T_RC_NS[GRADE]);
  localparam int C_RWC = dpc_pkg::cyc_up(dpc_pkg::T_RWC_NS[GRADE]);
  localparam int C_RP = dpc_pkg::cyc_up(dpc_pkg::T_RP_NS[GRADE]);
  localparam int C_RAS = dpc_pkg::cyc_up(dpc_pkg::T_RAS_NS[GRADE]);
  localparam int C_RMW_RAS =
    dpc_pkg::cyc_up(dpc_pkg::T_RMW_RAS_NS[GRADE]);
  localparam int C_CAS = dpc_pkg::cyc_up(dpc_pkg::T_CAS_NS[GRADE]);
  localparam int C_RMW_CAS =
    dpc_pkg::cyc_up(dpc_pkg::T_RMW_CAS_NS[GRADE]);
  localparam int C_CSH = dpc_pkg::cyc_up(dpc_pkg::T_CSH_NS[GRADE]);
  localparam int C_RSH = dpc_pkg::cyc_up(dpc_pkg::T_RSH_NS[GRADE]);
  localparam int C_RMW_RSH =
    dpc_pkg::cyc_up(dpc_pkg::T_RMW_RSH_NS[GRADE]);
  localparam int C_RAL = dpc_pkg::cyc_up(dpc_pkg::T_RAL_NS[GRADE]);
  localparam int C_OCH = dpc_pkg::cyc_up(dpc_pkg::T_OCH_NS[GRADE]);
  localparam int C_ORH = dpc_pkg::cyc_up(dpc_pkg::T_ORH_NS[GRADE]);
  localparam int C_CAC = dpc_pkg::cyc_up(dpc_pkg::T_CAC_NS[GRADE]);
  localparam int C_RAC = dpc_pkg::cyc_up(dpc_pkg::T_RAC_NS[GRADE]);
  localparam int C_AA = dpc_pkg::cyc_up(dpc_pkg::T_AA_NS[GRADE]);
  localparam int C_OEA = dpc_pkg::cyc_up(dpc_pkg::T_OEA_NS[GRADE]);
  localparam int C_WCH = dpc_pkg::cyc_up(dpc_pkg::T_WCH_NS[GRADE]);
  localparam int C_CWL = dpc_pkg::cyc_up(dpc_pkg::T_CWL_NS[GRADE]);
  localparam int C_RWL = dpc_pkg::cyc_up(dpc_pkg::T_RWL_NS[GRADE]);
  localparam int C_WP = dpc_pkg::cyc_up(dpc_pkg::T_WP_NS[GRADE]);
  localparam int C_DH = dpc_pkg::cyc_up(dpc_pkg::T_DH_NS[GRADE]);
  localparam int C_CWD = dpc_pkg::cyc_up(dpc_pkg::T_CWD_NS[GRADE]);
  localparam int C_RWD = dpc_pkg::cyc_up(dpc_pkg::T_RWD_NS[GRADE]);
  localparam int C_AWD = dpc_pkg::cyc_up(dpc_pkg::T_AWD_NS[GRADE]);
  localparam int C_ODD = dpc_pkg::cyc_up(dpc_pkg::T_ODD_NS);

  // row address phase; the column strobe falls C_EDGE after the row
  localparam int C_ROW = dpc_pkg::max2(dpc_pkg::cyc_up(dpc_pkg::T_RAD_NS),
    dpc_pkg::cyc_up(dpc_pkg::T_RAH_NS));
  localparam int C_EDGE = C_ROW + 1;

  // column low time of read and early write, the worst of all holds
  localparam int C_RD_A = dpc_pkg::max2(dpc_pkg::max2(C_CAS, C_CAC),
    dpc_pkg::max2(C_OCH, C_RSH));
  localparam int C_RD_B = dpc_pkg::max2(dpc_pkg::max2(C_ORH, C_AA - 1),
    dpc_pkg::max2(C_CSH - C_EDGE, C_RAC - C_EDGE));
  localparam int C_RD_C = dpc_pkg::max2(dpc_pkg::max2(C_RAL - 1, C_WCH),
    dpc_pkg::max2(C_CWL, C_RWL));
  localparam int C_RD = dpc_pkg::max2(dpc_pkg::max2(C_RD_A, C_RD_B),
    dpc_pkg::max2(C_RD_C, dpc_pkg::max2(C_DH, C_WP - 1)));

  // read half of read-modify-write: every store delay met
  localparam int C_RMW_A = dpc_pkg::max2(dpc_pkg::max2(C_CWD, C_CAC),
    dpc_pkg::max2(C_RWD - C_EDGE, C_RAC - C_EDGE));
  localparam int C_RMW_RD = dpc_pkg::max2(C_RMW_A,
    dpc_pkg::max2(C_AWD - 1, dpc_pkg::max2(C_OEA, C_AA - 1)));

  // store strobe low phase of delayed write and read-modify-write
  localparam int C_WLO = dpc_pkg::max2(dpc_pkg::max2(C_WP, C_CWL),
    dpc_pkg::max2(dpc_pkg::max2(C_RWL, C_DH), C_WCH));

  // recovery after a row cycle, used only for wake-up cycles
  localparam int C_WAKE_HI = dpc_pkg::max2(C_RP, C_RC - C_RAS);

  // timer wide enough for the power-up pause and every phase
  localparam int TW = dpc_pkg::max2($clog2(POWERUP_CYC + 1),
    dpc_pkg::CNT_W);
  localparam int WW = dpc_pkg::max2($clog2(IDLE_CYC + 1), 2);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef enum logic [3:0] {
    S_START, S_PAUSE, S_WAKE_LO, S_WAKE_HI, S_IDLE, S_ROW, S_COLA,
    S_CAS, S_OFF, S_WLO, S_HOLD, S_PRE
  } dpc_state_type;

  typedef struct packed {
    dpc_state_type state;
    dpc_pkg::dpc_kind_type kind;
    logic [dpc_pkg::ADDR_W-1:0] col;
    logic [dpc_pkg::DATA_W-1:0] wdata;
    dpc_pkg::dpc_pins_type pins;
    logic [dpc_pkg::WAKE_W-1:0] wakeLeft;
    logic [dpc_pkg::CNT_W-1:0] rowCnt;
    logic [dpc_pkg::CNT_W-1:0] colCnt;
    logic rowFell;
    logic rspValid;
    logic [dpc_pkg::DATA_W-1:0] rspData;
  } dpc_ctrl_type;

  localparam dpc_pkg::dpc_pins_type PINS_IDLE = '{
    rowStrobeN: 1'b1, colStrobeN: 1'b1, storeStrobeN: 1'b1,
    outGateN: 1'b1, addr: '0, dqOut: '0, dqOe: 1'b0};

  dpc_ctrl_type st;
  dpc_ctrl_type next_st;
  logic tLoad;
  logic [TW-1:0] tValue;
  logic tDone;
  logic stale;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // phase timer, restarted on every state change that needs one
  dpc_timer #(
    .W(TW)
  ) phaseTimer (
    .clk(clk),
    .rst(rst),
    .load(tLoad),
    .value(tValue),
    .done(tDone)
  );

  // watches for long row strobe silence
  dpc_row_watch #(
    .LIMIT(IDLE_CYC),
    .W(WW)
  ) rowWatch (
    .clk(clk),
    .rst(rst),
    .fell(st.rowFell),
    .stale(stale)
  );

  // ***************************************************************
  // sequencer
  // ***************************************************************
  // each phase loads the timer with its length less one on entry;
  // row and column counters measure the holds that span phases
  always_comb begin
    int rowMin;
    int colMin;
    int cycMin;
    rowMin = (st.kind == dpc_pkg::DPC_RMW) ? C_RMW_RAS : C_RAS;
    colMin = (st.kind == dpc_pkg::DPC_RMW) ?
      dpc_pkg::max2(C_RMW_CAS, C_RMW_RSH) : dpc_pkg::max2(C_CAS, C_RSH);
    cycMin = (st.kind == dpc_pkg::DPC_RMW) ? C_RWC : C_RC;
    next_st = st;
    next_st.rowFell = 1'b0;
    next_st.rspValid = 1'b0;
    tLoad = 1'b0;
    tValue = '0;
    if (st.rowCnt != '1) begin
      next_st.rowCnt = st.rowCnt + 1'b1;
    end
    if (st.colCnt != '1) begin
      next_st.colCnt = st.colCnt + 1'b1;
    end
    case (st.state)
      S_START: begin
        tLoad = 1'b1;
        tValue = TW'(POWERUP_CYC - 1);
        next_st.state = S_PAUSE;
      end
      S_PAUSE: begin
        if (tDone) begin
          next_st.wakeLeft = dpc_pkg::WAKE_W'(dpc_pkg::WAKE_CYCLES - 1);
          next_st.pins.rowStrobeN = 1'b0;
          next_st.rowFell = 1'b1;
          tLoad = 1'b1;
          tValue = TW'(C_RAS - 1);
          next_st.state = S_WAKE_LO;
        end
      end
      S_WAKE_LO: begin
        if (tDone) begin
          next_st.pins.rowStrobeN = 1'b1;
          tLoad = 1'b1;
          tValue = TW'(C_WAKE_HI - 1);
          next_st.state = S_WAKE_HI;
        end
      end
      S_WAKE_HI: begin
        if (tDone) begin
          if (st.wakeLeft == '0) begin
            next_st.state = S_IDLE;
          end else begin
            // eight row-only cycles in all
            next_st.wakeLeft = st.wakeLeft - 1'b1;
            next_st.pins.rowStrobeN = 1'b0;
            next_st.rowFell = 1'b1;
            tLoad = 1'b1;
            tValue = TW'(C_RAS - 1);
            next_st.state = S_WAKE_LO;
          end
        end
      end
      S_IDLE: begin
        if (stale) begin
          // a long silence needs the wake-up burst again
          next_st.wakeLeft = dpc_pkg::WAKE_W'(dpc_pkg::WAKE_CYCLES - 1);
          next_st.pins.addr = '0;
          next_st.pins.rowStrobeN = 1'b0;
          next_st.rowFell = 1'b1;
          tLoad = 1'b1;
          tValue = TW'(C_RAS - 1);
          next_st.state = S_WAKE_LO;
        end else if (reqValid) begin
          // the kind is chosen here, not inferred from strobe delays
          next_st.kind = req.kind;
          next_st.col = req.col;
          next_st.wdata = req.wdata;
          next_st.pins.addr = req.row;
          next_st.pins.rowStrobeN = 1'b0;
          next_st.rowFell = 1'b1;
          next_st.rowCnt = '0;
          tLoad = 1'b1;
          tValue = TW'(C_ROW - 1);
          next_st.state = S_ROW;
        end
      end
      S_ROW: begin
        if (tDone) begin
          next_st.pins.addr = st.col;
          if (st.kind == dpc_pkg::DPC_EARLY_WRITE) begin
            // store strobe and data lead the column strobe
            next_st.pins.storeStrobeN = 1'b0;
            next_st.pins.dqOut = st.wdata;
            next_st.pins.dqOe = 1'b1;
          end
          next_st.state = S_COLA;
        end
      end
      S_COLA: begin
        next_st.pins.colStrobeN = 1'b0;
        next_st.colCnt = '0;
        tLoad = 1'b1;
        case (st.kind)
          dpc_pkg::DPC_READ: begin
            // output gate opens with the column strobe
            next_st.pins.outGateN = 1'b0;
            tValue = TW'(C_RD - 1);
          end
          dpc_pkg::DPC_EARLY_WRITE: begin
            // output gate stays high: the device keeps its pins off
            tValue = TW'(C_RD - 1);
          end
          dpc_pkg::DPC_LATE_WRITE: begin
            // output gate held high well before the store strobe
            tValue = TW'(dpc_pkg::LATE_GAP_CYC - 1);
          end
          dpc_pkg::DPC_RMW: begin
            next_st.pins.outGateN = 1'b0;
            tValue = TW'(C_RMW_RD - 1);
          end
          default: begin
            tValue = TW'(C_RD - 1);
          end
        endcase
        next_st.state = S_CAS;
      end
      S_CAS: begin
        if (tDone) begin
          case (st.kind)
            dpc_pkg::DPC_READ: begin
              next_st.rspData = dqIn;
              next_st.state = S_HOLD;
            end
            dpc_pkg::DPC_LATE_WRITE: begin
              // read data undefined here, so it is never sampled
              next_st.pins.storeStrobeN = 1'b0;
              next_st.pins.dqOut = st.wdata;
              next_st.pins.dqOe = 1'b1;
              tLoad = 1'b1;
              tValue = TW'(C_WLO - 1);
              next_st.state = S_WLO;
            end
            dpc_pkg::DPC_RMW: begin
              // old word taken after every store delay has run
              next_st.rspData = dqIn;
              next_st.pins.outGateN = 1'b1;
              tLoad = 1'b1;
              tValue = TW'(C_ODD - 1);
              next_st.state = S_OFF;
            end
            default: begin
              next_st.state = S_HOLD;
            end
          endcase
        end
      end
      S_OFF: begin
        // data driven only after the device has let go of the pins
        if (tDone) begin
          next_st.pins.storeStrobeN = 1'b0;
          next_st.pins.dqOut = st.wdata;
          next_st.pins.dqOe = 1'b1;
          tLoad = 1'b1;
          tValue = TW'(C_WLO - 1);
          next_st.state = S_WLO;
        end
      end
      S_WLO: begin
        if (tDone) begin
          next_st.state = S_HOLD;
        end
      end
      S_HOLD: begin
        // both strobes rise together once every width is served;
        // the column address stays until then
        if (int'(st.rowCnt) >= rowMin - 1 &&
            int'(st.colCnt) >= colMin - 1) begin
          next_st.pins = PINS_IDLE;
          next_st.pins.addr = st.col;
          next_st.rspValid = 1'b1;
          tLoad = 1'b1;
          tValue = TW'(C_RP - 1);
          next_st.state = S_PRE;
        end
      end
      S_PRE: begin
        // store strobe stays high past the row rise in reads
        if (tDone && int'(st.rowCnt) >= cycMin - 2) begin
          next_st.state = S_IDLE;
        end
      end
      default: begin
        next_st.state = S_START;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{state: S_START, kind: dpc_pkg::DPC_READ, col: '0,
        wdata: '0, pins: PINS_IDLE, wakeLeft: '0, rowCnt: '0,
        colCnt: '0, rowFell: 1'b0, rspValid: 1'b0, rspData: '0};
    end else begin
      st <= next_st;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // taking a request is blocked while a wake-up burst is owed
  assign reqReady = (st.state == S_IDLE) && !stale;
  assign rspValid = st.rspValid;
  assign rspData = st.rspData;
  assign pins = st.pins;
endmodule
`default_nettype wire

// ==== verification/dpc_page_cycle_monitor.sv ====
// dpc_page_cycle_monitor.sv: pin timing checks of the controller.
// assumes: grade 0 counts at a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module dpc_page_cycle_monitor (
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic reqValid, // request offered
  input wire logic reqReady, // request taken
  input wire dpc_pkg::dpc_req_type req, // request
  input wire dpc_pkg::dpc_pins_type pins // memory pins
);
  // ****************
  // strobe checks
  // ****************
  logic [1:0] kind; // kind in flight
  // pins alone cannot tell the write variants apart
  always_ff @(posedge clk or posedge rst)
    if (rst) kind <= 2'h0;
    else if (reqValid && reqReady) kind <= req.kind;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_row11;
    !pins.rowStrobeN [*8] ##1 !pins.rowStrobeN [*3];
  endsequence
  a_row_low: assert property (
    $fell(pins.rowStrobeN) |-> !pins.rowStrobeN [*6]) else $error("row");
  a_col_low: assert property (
    $fell(pins.colStrobeN) |-> !pins.colStrobeN [*2]) else $error("col");
  a_col_hold: assert property (
    $rose(pins.colStrobeN) |-> !$past(pins.rowStrobeN, 6)) else $error("csh");
  a_row_hold: assert property (
    $rose(pins.rowStrobeN) && !$past(pins.colStrobeN)
    |-> !$past(pins.colStrobeN, 2)) else $error("rsh");
  a_gate_read: assert property (
    $fell(pins.outGateN) |-> (pins.storeStrobeN && !pins.colStrobeN &&
    !pins.rowStrobeN) [*2]) else $error("gate");
  // store strobe already low while the column strobe was still high
  a_early_store: assert property (
    $fell(pins.colStrobeN) && kind == dpc_pkg::DPC_EARLY_WRITE
    |-> !$past(pins.storeStrobeN) ##0 !pins.storeStrobeN [*2])
    else $error("early");
  a_col_store: assert property (
    $rose(pins.colStrobeN) && !$past(pins.storeStrobeN)
    |-> !$past(pins.storeStrobeN, 2)) else $error("cwl");
  a_row_store: assert property (
    $rose(pins.rowStrobeN) && !$past(pins.storeStrobeN)
    |-> !$past(pins.storeStrobeN, 2)) else $error("rwl");
  a_store_data: assert property (
    $fell(pins.storeStrobeN) |-> pins.dqOe ##1
    (pins.dqOe && $stable(pins.dqOut))) else $error("data");
  a_gate_high: assert property (
    $fell(pins.storeStrobeN) |-> pins.outGateN &&
    $past(pins.outGateN, 2)) else $error("oe");
  a_rmw_row: assert property (
    $fell(pins.rowStrobeN) && $past(reqValid && reqReady) &&
    kind == dpc_pkg::DPC_RMW |-> s_row11) else $error("rmw row");
  a_rmw_late: assert property (
    $fell(pins.storeStrobeN) && kind == dpc_pkg::DPC_RMW
    |-> !$past(pins.colStrobeN, 4) && !$past(pins.rowStrobeN, 9) &&
    $past(pins.addr, 6) == pins.addr) else $error("rmw late");
endmodule
bind dpc_page_cycle dpc_page_cycle_monitor mon (.clk, .rst, .reqValid,
  .reqReady, .req, .pins);
`default_nettype wire

// ==== verification/dpc_dram_model.sv ====
// dpc_dram_model.sv: behavioural 16-word slice of the memory.
// assumes: column bits 3:0 pick the word; no refresh decay.
`timescale 1ns/1ps
`default_nettype none
module dpc_dram_model (
  input wire dpc_pkg::dpc_pins_type pins, // controller pins
  output logic [15:0] dqIn // data pins as left by the memory
);
  // ****************
  // storage
  // ****************
  logic [15:0] mem [16];
  logic [15:0] last = 16'h5a5a;
  logic drive;
  // drives only in a read phase, so never in an early write
  assign drive = !pins.colStrobeN && !pins.outGateN && pins.storeStrobeN;
  // the later of the two falls latches the word
  always @(pins.colStrobeN or pins.storeStrobeN)
    if (!pins.colStrobeN && !pins.storeStrobeN)
      mem[pins.addr[3:0]] = pins.dqOut;
  // a released bus shows the inverse, not a stale copy
  always @* begin
    if (drive) last = mem[pins.addr[3:0]];
    dqIn = drive ? last : ~last;
  end
endmodule
`default_nettype wire

// ==== verification/test_dpc_page_cycle.sv ====
// test_dpc_page_cycle.sv: self-checking bench of the controller.
// assumes: grade 0, shortened pause and idle counts, 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin errCount++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module test_dpc_page_cycle;
  // ****************
  // bench
  // ****************
  localparam int PWR = 20;
  localparam int IDLE = 400;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqReady;
  dpc_pkg::dpc_req_type req = '0;
  logic rspValid;
  logic [15:0] rspData;
  dpc_pkg::dpc_pins_type pins;
  logic [15:0] dqIn;
  logic [15:0] q;
  int errCount = 0;
  int checksDone = 0;
  int falls = 0;
  int cyc = 0;
  int tk = 0;
  dpc_page_cycle #(.GRADE(0), .POWERUP_CYC(PWR), .IDLE_CYC(IDLE)) dut (
    .clk(clk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .rspValid(rspValid), .rspData(rspData), .pins(pins),
    .dqIn(dqIn));
  dpc_dram_model dram (.pins(pins), .dqIn(dqIn));
  // clock and cycle and row fall counters
  initial forever #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(negedge pins.rowStrobeN) falls++;
  task automatic finishTest();
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // request held until taken, then wait for the end pulse
  task automatic op(input logic [1:0] k, input logic [9:0] c,
      input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{dpc_pkg::dpc_kind_type'(k), 10'h001, c, d};
    do @(posedge clk); while (reqReady !== 1'b1 && n++ < 3000);
    reqValid <= 1'b0;
    tk = cyc;
    do @(posedge clk); while (rspValid !== 1'b1 && n++ < 3000);
    // a handshake that never completes counts as a mismatch
    if (n > 3000) errCount++;
    q = rspData;
  endtask
  task automatic t_wake();
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n++ < 1000) @(posedge clk);
    // a wake-up burst that never ends must not reach the pass verdict
    if (n > 1000) errCount++;
    `CHK(falls, 8)
    `CHK(cyc >= PWR + 8 * 11, 1'b1)
  endtask
  task automatic t_writes();
    op(2'h1, 10'h003, 16'ha5c3);
    op(2'h2, 10'h005, 16'h3c5a);
    op(2'h0, 10'h003, 16'h0000);
    `CHK(q, 16'ha5c3)
    op(2'h0, 10'h005, 16'h0000);
    `CHK(q, 16'h3c5a)
  endtask
  task automatic t_rmw();
    int t0;
    op(2'h3, 10'h003, 16'h0ff1);
    t0 = tk;
    `CHK(q, 16'ha5c3)
    op(2'h0, 10'h003, 16'h0000);
    `CHK(q, 16'h0ff1)
    `CHK(tk - t0 >= 16, 1'b1)
  endtask
  // long quiet row strobe must be followed by a fresh wake burst
  task automatic t_stale();
    int f0;
    f0 = falls;
    repeat (IDLE + 50) @(posedge clk);
    op(2'h0, 10'h005, 16'h0000);
    `CHK(falls - f0, 9)
    `CHK(q, 16'h3c5a)
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_wake();
    t_writes();
    t_rmw();
    t_stale();
    finishTest();
  end
  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    #200000;
    errCount++;
    finishTest();
  end
endmodule
`default_nettype wire
